// *** rtl/pcg_gating.sv ***
// Peripheral clock gating control: three gating sets, mode selection, bus-fault
// detection for gated units, APB register slave and event interrupt.
// Assumes pclk at 200 MHz, power mode and unit access inputs synchronous to it.
//
// Behaviour
// - Enable bit one clocks its unit; zero stops the clock, unit disabled.
// - Access to a gated-off unit answers with a bus fault.
// - All gating enable bits read zero after reset.
// - Separate run, sleep and deep-sleep gating sets govern their modes.
// - Sleep and deep-sleep sets apply only when automatic gating is set.
// - Group1 bit 4 gates sync serial, bits 1, 0 async serials.
// - Reserved bits are read-only zero; software writes back what it read.
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module pcg_gating (
  input  wire logic                  pclk,               // System clock
  input  wire logic                  presetn,            // Async reset, active low
  input  wire logic                  psel,               // APB select
  input  wire logic                  penable,            // APB access phase
  input  wire logic                  pwrite,             // APB write
  input  wire logic [11:0]           paddr,              // APB byte address
  input  wire logic [31:0]           pwdata,             // APB write data
  output logic      [31:0]           prdata,             // APB read data
  output logic                       pready,             // APB ready
  output logic                       pslverr,            // APB error
  input  wire pcg_pkg::pcg_mode_type power_mode,         // Current power state
  input  wire pcg_pkg::pcg_units_type unit_sel,          // Unit targeted by access
  input  wire logic                  unit_access,        // Access to a unit, pulse
  output logic                       unit_fault,         // Bus fault for that access
  output pcg_pkg::pcg_units_type     unit_clock_enable,  // Clock enable per unit
  output logic                       irq                 // Level interrupt
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Address to register identity, shared by read and write paths
  function automatic pcg_pkg::pcg_reg_type reg_of(input logic [11:0] addr);
    case (addr)
      pcg_pkg::RUN_GROUP0_OFFSET:    reg_of = pcg_pkg::PCG_R_RUN0;
      pcg_pkg::RUN_GROUP1_OFFSET:    reg_of = pcg_pkg::PCG_R_RUN1;
      pcg_pkg::SLEEP_GROUP0_OFFSET:  reg_of = pcg_pkg::PCG_R_SLEEP0;
      pcg_pkg::SLEEP_GROUP1_OFFSET:  reg_of = pcg_pkg::PCG_R_SLEEP1;
      pcg_pkg::DEEP_GROUP0_OFFSET:   reg_of = pcg_pkg::PCG_R_DEEP0;
      pcg_pkg::DEEP_GROUP1_OFFSET:   reg_of = pcg_pkg::PCG_R_DEEP1;
      pcg_pkg::RUN_CLOCK_CFG_OFFSET: reg_of = pcg_pkg::PCG_R_CFG;
      pcg_pkg::INT_STATUS_OFFSET:    reg_of = pcg_pkg::PCG_R_STATUS;
      pcg_pkg::INT_MASK_OFFSET:      reg_of = pcg_pkg::PCG_R_MASK;
      default:                       reg_of = pcg_pkg::PCG_R_NONE;
    endcase
  endfunction : reg_of

  // Group words to per-unit enables
  function automatic pcg_pkg::pcg_units_type units_of(input logic [31:0] g0,
                                                      input logic [31:0] g1);
    pcg_pkg::pcg_units_type u;
    u.comparator_one_clock_gate    = g1[pcg_pkg::COMP_ONE_BIT];
    u.comparator_zero_clock_gate   = g1[pcg_pkg::COMP_ZERO_BIT];
    u.gp_timer_two_clock_gate      = g1[pcg_pkg::TIMER_TWO_BIT];
    u.gp_timer_one_clock_gate      = g1[pcg_pkg::TIMER_ONE_BIT];
    u.gp_timer_zero_clock_gate     = g1[pcg_pkg::TIMER_ZERO_BIT];
    u.sync_serial_zero_clock_gate  = g1[pcg_pkg::SYNC_ZERO_BIT];
    u.async_serial_one_clock_gate  = g1[pcg_pkg::ASYNC_ONE_BIT];
    u.async_serial_zero_clock_gate = g1[pcg_pkg::ASYNC_ZERO_BIT];
    u.watchdog_clock_gate          = g0[pcg_pkg::WATCHDOG_BIT];
    u.hibernation_clock_gate       = g0[pcg_pkg::HIBERNATION_BIT];
    return u;
  endfunction : units_of

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [31:0]            run_mode_gate_group0;
  logic [31:0]            run_mode_gate_group1;
  logic [31:0]            sleep_mode_gate_group0;
  logic [31:0]            sleep_mode_gate_group1;
  logic [31:0]            deep_sleep_gate_group0;
  logic [31:0]            deep_sleep_gate_group1;
  logic [31:0]            run_clock_configuration;
  logic [31:0]            int_status;
  logic [31:0]            int_mask;
  logic                   automatic_gating_select;
  pcg_pkg::pcg_mode_type  last_mode;
  pcg_pkg::pcg_units_type next_unit_clock_enable;
  pcg_pkg::pcg_reg_type   sel_reg;
  logic                   wr_strobe;
  logic                   setup_phase;
  logic [31:0]            wdata;
  logic [31:0]            events;
  logic [31:0]            next_prdata;

  // Bus decode
  assign sel_reg     = reg_of(paddr);
  assign setup_phase = psel && !penable;
  assign wr_strobe   = psel && penable && pwrite;
  assign wdata       = pwdata;
  assign pready      = 1'b1;
  assign pslverr     = psel && penable && (sel_reg == pcg_pkg::PCG_R_NONE);
  assign automatic_gating_select = run_clock_configuration[pcg_pkg::AUTO_GATING_BIT];

  // ----------------------------------------------------------------
  // Gating register sets
  // ----------------------------------------------------------------
  // Writable bits only; reserved bits stay zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_mode_gate_group0   <= pcg_pkg::REG_RESET;
      run_mode_gate_group1   <= pcg_pkg::REG_RESET;
      sleep_mode_gate_group0 <= pcg_pkg::REG_RESET;
      sleep_mode_gate_group1 <= pcg_pkg::REG_RESET;
      deep_sleep_gate_group0 <= pcg_pkg::REG_RESET;
      deep_sleep_gate_group1 <= pcg_pkg::REG_RESET;
    end
    else if (wr_strobe)
    begin
      case (sel_reg)
        pcg_pkg::PCG_R_RUN0:   run_mode_gate_group0   <= wdata & pcg_pkg::GROUP0_WRITE_MASK;
        pcg_pkg::PCG_R_RUN1:   run_mode_gate_group1   <= wdata & pcg_pkg::GROUP1_WRITE_MASK;
        pcg_pkg::PCG_R_SLEEP0: sleep_mode_gate_group0 <= wdata & pcg_pkg::GROUP0_WRITE_MASK;
        pcg_pkg::PCG_R_SLEEP1: sleep_mode_gate_group1 <= wdata & pcg_pkg::GROUP1_WRITE_MASK;
        pcg_pkg::PCG_R_DEEP0:  deep_sleep_gate_group0 <= wdata & pcg_pkg::GROUP0_WRITE_MASK;
        pcg_pkg::PCG_R_DEEP1:  deep_sleep_gate_group1 <= wdata & pcg_pkg::GROUP1_WRITE_MASK;
        default:               ;
      endcase
    end
  end

  // Run clock configuration, only the automatic gating bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_clock_configuration <= pcg_pkg::REG_RESET;
    else if (wr_strobe && sel_reg == pcg_pkg::PCG_R_CFG)
      run_clock_configuration <= wdata & pcg_pkg::CFG_WRITE_MASK;
  end

  // ----------------------------------------------------------------
  // Mode selection and unit clock enables
  // ----------------------------------------------------------------
  // Pick the set governing the current power state
  always_comb
  begin
    next_unit_clock_enable = units_of(run_mode_gate_group0, run_mode_gate_group1);
    case (power_mode)
      pcg_pkg::PCG_RUN: ;
      pcg_pkg::PCG_SLEEP:
        if (automatic_gating_select)
          next_unit_clock_enable = units_of(sleep_mode_gate_group0, sleep_mode_gate_group1);
      pcg_pkg::PCG_DEEP_SLEEP:
        if (automatic_gating_select)
          next_unit_clock_enable = units_of(deep_sleep_gate_group0, deep_sleep_gate_group1);
      default: ;
    endcase
  end

  // Registered enables drive the unit clock gates
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      unit_clock_enable <= '0;
    else
      unit_clock_enable <= next_unit_clock_enable;
  end

  // Access to a unit whose clock is off faults
  assign unit_fault = unit_access && |(unit_sel & ~unit_clock_enable);

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------
  assign events = {30'h0000_0000, (power_mode != last_mode), unit_fault};

  // Remember mode for change detection
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      last_mode <= pcg_pkg::PCG_RUN;
    else
      last_mode <= power_mode;
  end

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_status <= pcg_pkg::REG_RESET;
    else if (wr_strobe && sel_reg == pcg_pkg::PCG_R_STATUS)
      int_status <= (int_status & ~(wdata & pcg_pkg::EVENT_MASK)) | events;
    else
      int_status <= int_status | events;
  end

  // Interrupt mask
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_mask <= pcg_pkg::REG_RESET;
    else if (wr_strobe && sel_reg == pcg_pkg::PCG_R_MASK)
      int_mask <= wdata & pcg_pkg::EVENT_MASK;
  end

  assign irq = |(int_status & int_mask);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Read mux, captured in the setup phase
  always_comb
  begin
    case (sel_reg)
      pcg_pkg::PCG_R_RUN0:   next_prdata = run_mode_gate_group0;
      pcg_pkg::PCG_R_RUN1:   next_prdata = run_mode_gate_group1;
      pcg_pkg::PCG_R_SLEEP0: next_prdata = sleep_mode_gate_group0;
      pcg_pkg::PCG_R_SLEEP1: next_prdata = sleep_mode_gate_group1;
      pcg_pkg::PCG_R_DEEP0:  next_prdata = deep_sleep_gate_group0;
      pcg_pkg::PCG_R_DEEP1:  next_prdata = deep_sleep_gate_group1;
      pcg_pkg::PCG_R_CFG:    next_prdata = run_clock_configuration;
      pcg_pkg::PCG_R_STATUS: next_prdata = int_status;
      pcg_pkg::PCG_R_MASK:   next_prdata = int_mask;
      default:               next_prdata = pcg_pkg::REG_RESET;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= pcg_pkg::REG_RESET;
    else if (setup_phase && !pwrite)
      prdata <= next_prdata;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reset_gates_off: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (unit_clock_enable == '0 && run_mode_gate_group1 == 32'h0000_0000))
    else $error("unit clocks not off after reset");

  a_gated_access_faults: assert property (@(posedge pclk) disable iff (!presetn)
    (unit_access && (unit_sel & ~unit_clock_enable) != '0) |-> unit_fault)
    else $error("access to gated unit did not fault");

  a_clocked_no_fault: assert property (@(posedge pclk) disable iff (!presetn)
    (unit_access && (unit_sel & ~unit_clock_enable) == '0) |-> !unit_fault)
    else $error("fault raised for clocked unit");

  a_run_set_applies: assert property (@(posedge pclk) disable iff (!presetn)
    (power_mode == pcg_pkg::PCG_RUN) |=>
      unit_clock_enable == units_of($past(run_mode_gate_group0), $past(run_mode_gate_group1)))
    else $error("run set not applied in run mode");

  a_sleep_needs_auto: assert property (@(posedge pclk) disable iff (!presetn)
    (power_mode == pcg_pkg::PCG_SLEEP && !automatic_gating_select) |=>
      unit_clock_enable == units_of($past(run_mode_gate_group0), $past(run_mode_gate_group1)))
    else $error("sleep set used without automatic gating");

  a_deep_set_applies: assert property (@(posedge pclk) disable iff (!presetn)
    (power_mode == pcg_pkg::PCG_DEEP_SLEEP && automatic_gating_select) |=>
      unit_clock_enable.watchdog_clock_gate == $past(deep_sleep_gate_group0[3]) &&
      unit_clock_enable.hibernation_clock_gate == $past(deep_sleep_gate_group0[6]))
    else $error("deep sleep group0 not applied");

  a_group1_write_map: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_strobe && sel_reg == pcg_pkg::PCG_R_RUN1) |=>
      run_mode_gate_group1 == ($past(pwdata) & 32'h0307_0013))
    else $error("group1 write not stored through writable mask");

  a_reserved_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite) |-> (prdata & ~32'h0307_005B) == 32'h0000_0000 ||
      sel_reg == pcg_pkg::PCG_R_NONE)
    else $error("reserved bits read nonzero");

  a_fault_sets_status: assert property (@(posedge pclk) disable iff (!presetn)
    unit_fault |=> int_status[pcg_pkg::FAULT_EVENT_BIT] &&
      (!int_mask[pcg_pkg::FAULT_EVENT_BIT] || irq))
    else $error("fault event not latched");

  // Sleep set governs sleep with automatic gating on
  a_sleep_set_applies: assert property (@(posedge pclk) disable iff (!presetn)
    (power_mode == pcg_pkg::PCG_SLEEP && automatic_gating_select) |=>
      unit_clock_enable == units_of($past(sleep_mode_gate_group0),
                                    $past(sleep_mode_gate_group1)))
    else $error("sleep set not applied with automatic gating");

  // Deep sleep without automatic gating keeps the run set
  a_deep_needs_auto: assert property (@(posedge pclk) disable iff (!presetn)
    (power_mode == pcg_pkg::PCG_DEEP_SLEEP && !automatic_gating_select) |=>
      unit_clock_enable == units_of($past(run_mode_gate_group0), $past(run_mode_gate_group1)))
    else $error("deep sleep set used without automatic gating");

  // Deep sleep set governs every unit with automatic gating on
  a_deep_units_follow: assert property (@(posedge pclk) disable iff (!presetn)
    (power_mode == pcg_pkg::PCG_DEEP_SLEEP && automatic_gating_select) |=>
      unit_clock_enable == units_of($past(deep_sleep_gate_group0),
                                    $past(deep_sleep_gate_group1)))
    else $error("deep sleep set not applied");

  // Group0 writes keep only the hibernation and watchdog bits
  a_group0_write_map: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_strobe && sel_reg == pcg_pkg::PCG_R_DEEP0) |=>
      deep_sleep_gate_group0 == ($past(pwdata) & pcg_pkg::GROUP0_WRITE_MASK))
    else $error("deep group0 write not stored through writable mask");

  // Sleep group1 writes keep only the unit bits
  a_sleep1_write_map: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_strobe && sel_reg == pcg_pkg::PCG_R_SLEEP1) |=>
      sleep_mode_gate_group1 == ($past(pwdata) & pcg_pkg::GROUP1_WRITE_MASK))
    else $error("sleep group1 write not stored through writable mask");

  // Deep group1 writes keep only the unit bits
  a_deep1_write_map: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_strobe && sel_reg == pcg_pkg::PCG_R_DEEP1) |=>
      deep_sleep_gate_group1 == ($past(pwdata) & pcg_pkg::GROUP1_WRITE_MASK))
    else $error("deep group1 write not stored through writable mask");

  // Every gating set is clear when reset ends
  a_reset_sets_clear: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (run_mode_gate_group0 | run_mode_gate_group1 | sleep_mode_gate_group0 |
      sleep_mode_gate_group1 | deep_sleep_gate_group0 | deep_sleep_gate_group1) ==
      pcg_pkg::REG_RESET)
    else $error("gating sets not clear after reset");

  // Unmapped reads answer an error and zero data
  a_unmapped_refused: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pwrite && sel_reg == pcg_pkg::PCG_R_NONE) |->
      (pslverr && prdata == pcg_pkg::REG_RESET))
    else $error("unmapped read not refused");

  // Writing one clears the fault flag when no new fault arrives
  a_status_w1c: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_strobe && sel_reg == pcg_pkg::PCG_R_STATUS && pwdata[pcg_pkg::FAULT_EVENT_BIT] &&
      !unit_fault) |=> !int_status[pcg_pkg::FAULT_EVENT_BIT])
    else $error("fault flag not cleared by write of one");

  // A change of power state raises the mode event
  a_mode_event_sets: assert property (@(posedge pclk) disable iff (!presetn)
    ($past(presetn) && power_mode != $past(power_mode)) |=>
      int_status[pcg_pkg::MODE_EVENT_BIT])
    else $error("mode change not latched");

endmodule : pcg_gating

// *** rtl/pcg_pkg.sv ***
// Constants, register map and carrier types of the peripheral clock gating block.
// Assumes a 32-bit APB master with a 12-bit offset address.
package pcg_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] RUN_GROUP0_OFFSET   = 12'h100;
  localparam logic [11:0] RUN_GROUP1_OFFSET   = 12'h104;
  localparam logic [11:0] SLEEP_GROUP0_OFFSET = 12'h110;
  localparam logic [11:0] SLEEP_GROUP1_OFFSET = 12'h114;
  localparam logic [11:0] DEEP_GROUP0_OFFSET  = 12'h120;
  localparam logic [11:0] DEEP_GROUP1_OFFSET  = 12'h124;
  localparam logic [11:0] RUN_CLOCK_CFG_OFFSET = 12'h130;
  localparam logic [11:0] INT_STATUS_OFFSET   = 12'h140;
  localparam logic [11:0] INT_MASK_OFFSET     = 12'h144;

  // ----------------------------------------------------------------
  // Field positions, writable masks and reset values
  // ----------------------------------------------------------------
  localparam int HIBERNATION_BIT = 6;
  localparam int WATCHDOG_BIT    = 3;
  localparam int COMP_ONE_BIT    = 25;
  localparam int COMP_ZERO_BIT   = 24;
  localparam int TIMER_TWO_BIT   = 18;
  localparam int TIMER_ONE_BIT   = 17;
  localparam int TIMER_ZERO_BIT  = 16;
  localparam int SYNC_ZERO_BIT   = 4;
  localparam int ASYNC_ONE_BIT   = 1;
  localparam int ASYNC_ZERO_BIT  = 0;
  localparam int AUTO_GATING_BIT = 0;
  localparam int FAULT_EVENT_BIT = 0;
  localparam int MODE_EVENT_BIT  = 1;

  localparam logic [31:0] GROUP0_WRITE_MASK = 32'h0000_0048;
  localparam logic [31:0] GROUP1_WRITE_MASK = 32'h0307_0013;
  localparam logic [31:0] CFG_WRITE_MASK    = 32'h0000_0001;
  localparam logic [31:0] EVENT_MASK        = 32'h0000_0003;
  localparam logic [31:0] REG_RESET         = 32'h0000_0000;
  localparam int          UNIT_COUNT        = 10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {PCG_RUN, PCG_SLEEP, PCG_DEEP_SLEEP} pcg_mode_type;

  typedef enum logic [3:0] {
    PCG_R_RUN0, PCG_R_RUN1, PCG_R_SLEEP0, PCG_R_SLEEP1, PCG_R_DEEP0, PCG_R_DEEP1,
    PCG_R_CFG, PCG_R_STATUS, PCG_R_MASK, PCG_R_NONE
  } pcg_reg_type;

  // One enable per controlled unit
  typedef struct packed {
    logic comparator_one_clock_gate;
    logic comparator_zero_clock_gate;
    logic gp_timer_two_clock_gate;
    logic gp_timer_one_clock_gate;
    logic gp_timer_zero_clock_gate;
    logic sync_serial_zero_clock_gate;
    logic async_serial_one_clock_gate;
    logic async_serial_zero_clock_gate;
    logic watchdog_clock_gate;
    logic hibernation_clock_gate;
  } pcg_units_type;

endpackage : pcg_pkg

// *** verif/pcg_core_model.sv ***
// Processor core model: APB master and unit access source for the gating block.
// Assumes one clock pclk; tasks are entered just after a rising edge.
`timescale 1ns/1ps
module pcg_core_model (
  input  wire logic              pclk,        // System clock
  output logic                   psel,        // APB select
  output logic                   penable,     // APB access phase
  output logic                   pwrite,      // APB write
  output logic [11:0]            paddr,       // APB byte address
  output logic [31:0]            pwdata,      // APB write data
  input  wire logic [31:0]       prdata,      // APB read data
  input  wire logic              pready,      // APB ready
  input  wire logic              pslverr,     // APB error
  output pcg_pkg::pcg_units_type unit_sel,    // Targeted unit
  output logic                   unit_access, // Access pulse
  input  wire logic              unit_fault   // Bus fault answer
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial
  begin
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 12'hFFF;
    pwdata      = 32'hA5A5_A5A5;
    unit_sel    = '0;
    unit_access = 1'b0;
  end

  // One transfer; request held until pready is seen high
  task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
                          output logic [31:0] rd, output logic err);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd       = prdata;
    err      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~addr;  // Released bus shows no stale value
    pwdata  <= ~wd;
    @(posedge pclk);
  endtask : apb_xfer

  // One-cycle unit access; fault sampled in that cycle
  task automatic touch_unit(input pcg_pkg::pcg_units_type sel, output logic fault);
    unit_sel    <= sel;
    unit_access <= 1'b1;
    @(posedge pclk);
    fault        = unit_fault;
    unit_access <= 1'b0;
    unit_sel    <= ~sel;
    @(posedge pclk);
  endtask : touch_unit
endmodule : pcg_core_model

// *** verif/pcg_gating_tb.sv ***
// Self-checking bench of the peripheral clock gating block.
// Assumes pcg_pkg, pcg_gating and pcg_core_model are compiled first.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin errors++; \
  $display("unexpected at %0t: got %0h, expected %0h", $time, got, exp); end end
module pcg_gating_tb;
  // ----------------------------------------------------------------
  // Signals and tables
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, unit_access, unit_fault, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  pcg_pkg::pcg_mode_type  power_mode;
  pcg_pkg::pcg_units_type unit_sel, unit_clock_enable;
  int errors, n_checks;
  logic f;
  localparam logic [11:0] GATE_ADDR [6] = '{12'h100, 12'h104, 12'h110, 12'h114, 12'h120, 12'h124};
  localparam logic [31:0] G0_SET [3] = '{32'h0000_0008, 32'h0000_0040, 32'h0000_0048};
  localparam logic [31:0] G1_SET [3] = '{32'h0000_0013, 32'h0307_0000, 32'h0001_0010};
  localparam pcg_pkg::pcg_mode_type MODES [5] = '{pcg_pkg::PCG_RUN, pcg_pkg::PCG_SLEEP,
    pcg_pkg::PCG_DEEP_SLEEP, pcg_pkg::PCG_SLEEP, pcg_pkg::PCG_DEEP_SLEEP};
  localparam logic [31:0] AUTO [5] = '{32'h1, 32'h1, 32'h1, 32'h0, 32'h0};
  localparam int          SETI [5] = '{0, 1, 2, 0, 0};

  pcg_gating pcg_gating_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .power_mode(power_mode), .unit_sel(unit_sel),
    .unit_access(unit_access), .unit_fault(unit_fault),
    .unit_clock_enable(unit_clock_enable), .irq(irq));
  pcg_core_model pcg_core_model_inst (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .unit_sel(unit_sel), .unit_access(unit_access),
    .unit_fault(unit_fault));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Expected enables from one group0 and one group1 value
  function automatic pcg_pkg::pcg_units_type units_of(input logic [31:0] g0,
                                                      input logic [31:0] g1);
    return {g1[25], g1[24], g1[18], g1[17], g1[16], g1[4], g1[1], g1[0], g0[3], g0[6]};
  endfunction : units_of

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    pcg_core_model_inst.apb_xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic        e;
    pcg_core_model_inst.apb_xfer(1'b0, a, 32'h0000_0000, r, e);
    `CHK({e, r}, {exp_err, exp})
  endtask : rd_chk

  task automatic close_out();
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // Clock and watchdog
  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;
  initial
  begin
    repeat (4000) @(posedge pclk);
    errors++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    errors = 0;
    n_checks = 0;
    presetn = 1'b0;
    power_mode = pcg_pkg::PCG_RUN;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values
    for (int i = 0; i < 6; i++) rd_chk(GATE_ADDR[i], 32'h0000_0000, 1'b0);
    rd_chk(12'h130, 32'h0000_0000, 1'b0);
    `CHK(unit_clock_enable, 10'h000)
    // Every unit faults while gated; fault event raises irq
    wr(12'h144, 32'h0000_0001);
    for (int i = 0; i < 10; i++)
    begin
      pcg_core_model_inst.touch_unit(10'h001 << i, f);
      `CHK(f, 1'b1)
    end
    `CHK(irq, 1'b1)
    rd_chk(12'h140, 32'h0000_0001, 1'b0);
    wr(12'h140, 32'h0000_0001);
    rd_chk(12'h140, 32'h0000_0000, 1'b0);
    `CHK(irq, 1'b0)
    // Writable bits only; reserved bits read zero
    for (int i = 0; i < 6; i++)
    begin
      wr(GATE_ADDR[i], 32'hFFFF_FFFF);
      rd_chk(GATE_ADDR[i], (i % 2) ? 32'h0307_0013 : 32'h0000_0048, 1'b0);
    end
    wr(12'h130, 32'hFFFF_FFFF);
    rd_chk(12'h130, 32'h0000_0001, 1'b0);
    `CHK(unit_clock_enable, 10'h3FF)
    // Enabled before access, so no unit faults
    for (int i = 0; i < 10; i++)
    begin
      pcg_core_model_inst.touch_unit(10'h001 << i, f);
      `CHK(f, 1'b0)
    end
    // Unmapped place refuses
    wr(12'h200, 32'hFFFF_FFFF);
    rd_chk(12'h200, 32'h0000_0000, 1'b1);
    // Distinct sets, then every mode with automatic gating, and sleep and deep sleep without it
    for (int s = 0; s < 3; s++)
    begin
      wr(GATE_ADDR[2 * s], G0_SET[s]);
      wr(GATE_ADDR[2 * s + 1], G1_SET[s]);
    end
    wr(12'h144, 32'h0000_0002);
    for (int m = 0; m < 5; m++)
    begin
      wr(12'h130, AUTO[m]);
      power_mode <= MODES[m];
      repeat (2) @(posedge pclk);
      `CHK(unit_clock_enable, units_of(G0_SET[SETI[m]], G1_SET[SETI[m]]))
    end
    `CHK(irq, 1'b1)
    rd_chk(12'h140, 32'h0000_0002, 1'b0);
    power_mode <= pcg_pkg::PCG_RUN;
    wr(12'h144, 32'h0000_0000);
    `CHK(irq, 1'b0)
    wr(12'h140, 32'h0000_0003);
    rd_chk(12'h140, 32'h0000_0000, 1'b0);
    // Second reset in mid-run clears all enables
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(12'h104, 32'h0000_0000, 1'b0);
    `CHK(unit_clock_enable, 10'h000)
    close_out();
  end
endmodule : pcg_gating_tb
